// ===== rtl/xlate_pkg.sv
// Constants and types for the bus-master address translation path
// Contract
// - Translate linear addresses via directory and table
// - Paged mode treats every address as linear
// - Local-versus-system decision uses translated physical address
// - User mode blocks directory base updates
// - Narrow slot limits system accesses to 24 bits
// - Page fault raises shared adapter interrupt request
// - Report narrow or wide slot to software
package xlate_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] PAGE_BASE_MASK = 32'hFFFFF000;
   localparam int DIR_IDX_HI = 31;
   localparam int DIR_IDX_LO = 22;
   localparam int TBL_IDX_HI = 21;
   localparam int TBL_IDX_LO = 12;
   localparam int OFS_HI = 11;
   localparam int PRESENT_BIT = 0;
   localparam logic [31:0] NARROW_LIMIT_MASK = 32'hFF000000;
   localparam logic [31:0] PDBR_RESET = 32'h00000000;
   localparam logic [31:0] VMEM_BASE_RESET = 32'h00000000;
   localparam logic [31:0] VMEM_SIZE_RESET = 32'h00100000;
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_DIR = 2'h1;
   localparam logic [1:0] FAULT_TBL = 2'h2;
   localparam logic [1:0] FAULT_RANGE = 2'h3;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_DIR   = 6'h02,
      ST_TBL   = 6'h04,
      ST_ISSUE = 6'h08,
      ST_WAIT  = 6'h10,
      ST_FAULT = 6'h20
   } xlate_state_t;
endpackage

// ===== rtl/slot_limit.sv
// Narrow-slot address limit and memory target decode
`timescale 1ns/1ps
module slot_limit
   import xlate_pkg::*;
(
   input  wire logic [31:0] phys_addr,
   input  wire logic        narrow_slot,
   input  wire logic [31:0] vmem_base,
   input  wire logic [31:0] vmem_size,
   output logic             is_local,
   output logic             out_of_range
);
   // Local video window test on the physical address
   always_comb begin
      is_local = (phys_addr >= vmem_base) && ((phys_addr - vmem_base) < vmem_size);
      out_of_range = narrow_slot && !is_local && ((phys_addr & NARROW_LIMIT_MASK) != 32'h00000000);
   end
endmodule

// ===== rtl/xlate_path.sv
// Bus-master address generation with optional paged translation
`timescale 1ns/1ps
module xlate_path
   import xlate_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        narrow_slot,
   input  wire logic        paged_translation_mode,
   input  wire logic        user_mode,
   input  wire logic        pdbr_wr,
   input  wire logic [31:0] pdbr_wdata,
   input  wire logic [31:0] vmem_base,
   input  wire logic [31:0] vmem_size,
   input  wire logic        req_valid,
   input  wire logic [31:0] req_addr,
   input  wire logic        req_write,
   output logic             req_ready,
   output logic             done_r,
   output logic             bus_req_r,
   output logic [31:0]      bus_addr_r,
   output logic             bus_write_r,
   output logic             bus_local_r,
   input  wire logic        bus_ack,
   input  wire logic [31:0] bus_rdata,
   input  wire logic        fault_clear,
   output logic             irq_r,
   output logic [1:0]       fault_code_r,
   output logic [31:0]      fault_addr_r,
   output logic [31:0]      pdbr_r,
   output logic             slot_narrow_r
);
   import xlate_pkg::*;

   xlate_state_t state_r;
   logic [31:0]  lin_r;
   logic         write_r;
   logic [31:0]  phys;
   logic         is_local;
   logic         out_of_range;
   logic         ready_r;

   // Entry address helpers
   function automatic logic [31:0] dir_entry_addr(input logic [31:0] base, input logic [31:0] lin);
      dir_entry_addr = (base & PAGE_BASE_MASK) | {20'h00000, lin[DIR_IDX_HI:DIR_IDX_LO], 2'h0};
   endfunction

   function automatic logic [31:0] tbl_entry_addr(input logic [31:0] base, input logic [31:0] lin);
      tbl_entry_addr = (base & PAGE_BASE_MASK) | {20'h00000, lin[TBL_IDX_HI:TBL_IDX_LO], 2'h0};
   endfunction

   // Slot limit on system accesses, walk reads included
   // Directory and table reads always go to system memory
   function automatic logic above_narrow(input logic narrow, input logic [31:0] addr);
      above_narrow = narrow && ((addr & NARROW_LIMIT_MASK) != 32'h00000000);
   endfunction

   // Final address: page frame plus offset when paged, else direct
   always_comb begin
      if (paged_translation_mode) begin
         phys = (bus_rdata & PAGE_BASE_MASK) | {20'h00000, lin_r[OFS_HI:0]};
      end else begin
         phys = lin_r;
      end
   end

   slot_limit u_limit (
      .phys_addr    (phys),
      .narrow_slot  (narrow_slot),
      .vmem_base    (vmem_base),
      .vmem_size    (vmem_size),
      .is_local     (is_local),
      .out_of_range (out_of_range)
   );

   // Ready straight from its flip-flop
   assign req_ready = ready_r;

   // Directory base register, supervisor only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pdbr_r <= PDBR_RESET;
      end else if (pdbr_wr && !user_mode) begin
         pdbr_r <= pdbr_wdata & PAGE_BASE_MASK;
      end
   end

   // Slot width status for software
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slot_narrow_r <= 1'b0;
      end else begin
         slot_narrow_r <= narrow_slot;
      end
   end

   // Translation walk and bus sequencing
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= ST_IDLE;
         lin_r        <= 32'h00000000;
         write_r      <= 1'b0;
         bus_req_r    <= 1'b0;
         bus_addr_r   <= 32'h00000000;
         bus_write_r  <= 1'b0;
         bus_local_r  <= 1'b0;
         ready_r      <= 1'b0;
         done_r       <= 1'b0;
         irq_r        <= 1'b0;
         fault_code_r <= FAULT_NONE;
         fault_addr_r <= 32'h00000000;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               ready_r <= 1'b1;
               if (req_valid && ready_r) begin
                  ready_r <= 1'b0;
                  lin_r   <= req_addr;
                  write_r <= req_write;
                  if (!paged_translation_mode) begin
                     state_r <= ST_ISSUE;
                  end else if (above_narrow(narrow_slot, dir_entry_addr(pdbr_r, req_addr))) begin
                     fault_code_r <= FAULT_RANGE;
                     fault_addr_r <= req_addr;
                     irq_r        <= 1'b1;
                     state_r      <= ST_FAULT;
                  end else begin
                     bus_req_r   <= 1'b1;
                     bus_write_r <= 1'b0;
                     bus_local_r <= 1'b0;
                     bus_addr_r  <= dir_entry_addr(pdbr_r, req_addr);
                     state_r     <= ST_DIR;
                  end
               end
            end
            ST_DIR: begin
               if (bus_ack) begin
                  if (!bus_rdata[PRESENT_BIT]) begin
                     bus_req_r    <= 1'b0;
                     fault_code_r <= FAULT_DIR;
                     fault_addr_r <= lin_r;
                     irq_r        <= 1'b1;
                     state_r      <= ST_FAULT;
                  end else if (above_narrow(narrow_slot, tbl_entry_addr(bus_rdata, lin_r))) begin
                     bus_req_r    <= 1'b0;
                     fault_code_r <= FAULT_RANGE;
                     fault_addr_r <= lin_r;
                     irq_r        <= 1'b1;
                     state_r      <= ST_FAULT;
                  end else begin
                     bus_addr_r <= tbl_entry_addr(bus_rdata, lin_r);
                     state_r    <= ST_TBL;
                  end
               end
            end
            ST_TBL: begin
               if (bus_ack) begin
                  bus_req_r <= 1'b0;
                  if (!bus_rdata[PRESENT_BIT]) begin
                     fault_code_r <= FAULT_TBL;
                     fault_addr_r <= lin_r;
                     irq_r        <= 1'b1;
                     state_r      <= ST_FAULT;
                  end else if (out_of_range) begin
                     fault_code_r <= FAULT_RANGE;
                     fault_addr_r <= lin_r;
                     irq_r        <= 1'b1;
                     state_r      <= ST_FAULT;
                  end else begin
                     bus_req_r   <= 1'b1;
                     bus_addr_r  <= phys;
                     bus_write_r <= write_r;
                     bus_local_r <= is_local;
                     state_r     <= ST_WAIT;
                  end
               end
            end
            ST_ISSUE: begin
               if (out_of_range) begin
                  fault_code_r <= FAULT_RANGE;
                  fault_addr_r <= lin_r;
                  irq_r        <= 1'b1;
                  state_r      <= ST_FAULT;
               end else begin
                  bus_req_r   <= 1'b1;
                  bus_addr_r  <= lin_r;
                  bus_write_r <= write_r;
                  bus_local_r <= is_local;
                  state_r     <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (bus_ack) begin
                  bus_req_r <= 1'b0;
                  done_r    <= 1'b1;
                  state_r   <= ST_IDLE;
               end
            end
            ST_FAULT: begin
               if (fault_clear) begin
                  irq_r        <= 1'b0;
                  fault_code_r <= FAULT_NONE;
                  if (!paged_translation_mode) begin
                     state_r <= ST_ISSUE;
                  end else if (above_narrow(narrow_slot, dir_entry_addr(pdbr_r, lin_r))) begin
                     irq_r        <= 1'b1;
                     fault_code_r <= FAULT_RANGE;
                  end else begin
                     bus_req_r   <= 1'b1;
                     bus_write_r <= 1'b0;
                     bus_local_r <= 1'b0;
                     bus_addr_r  <= dir_entry_addr(pdbr_r, lin_r);
                     state_r     <= ST_DIR;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ===== tb/xlate_path_checker.sv
// Port assertions for the translation path
`timescale 1ns/1ps
module xlate_path_checker
   import xlate_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        narrow_slot,
   input wire logic        paged_translation_mode,
   input wire logic        user_mode,
   input wire logic        pdbr_wr,
   input wire logic [31:0] pdbr_wdata,
   input wire logic [31:0] vmem_base,
   input wire logic [31:0] vmem_size,
   input wire logic        req_valid,
   input wire logic [31:0] req_addr,
   input wire logic        req_ready,
   input wire logic        done_r,
   input wire logic        bus_req_r,
   input wire logic [31:0] bus_addr_r,
   input wire logic        bus_local_r,
   input wire logic        bus_ack,
   input wire logic        fault_clear,
   input wire logic        irq_r,
   input wire logic [1:0]  fault_code_r,
   input wire logic [31:0] pdbr_r,
   input wire logic        slot_narrow_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Request taken and final data access
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_last; bus_req_r && bus_ack ##1 done_r; endsequence
   // Translation steps, target decode, directory base, slot and fault
   property p_dir_read;
      s_take ##0 (paged_translation_mode && (!narrow_slot || (pdbr_r & NARROW_LIMIT_MASK) == 32'h0)) |=>
         bus_req_r && bus_addr_r == ($past(pdbr_r) | {20'h0, $past(req_addr[31:22]), 2'h0});
   endproperty
   property p_dir_block;
      s_take ##0 (paged_translation_mode && narrow_slot && (pdbr_r & NARROW_LIMIT_MASK) != 32'h0) |=>
         irq_r && !bus_req_r && fault_code_r == FAULT_RANGE;
   endproperty
   property p_local;
      s_last |-> $past(bus_local_r) == (($past(bus_addr_r) - vmem_base) < vmem_size);
   endproperty
   property p_user_lock; pdbr_wr && user_mode |=> $stable(pdbr_r); endproperty
   property p_pdbr_set; pdbr_wr && !user_mode |=> pdbr_r == ($past(pdbr_wdata) & PAGE_BASE_MASK); endproperty
   property p_slot; 1'b1 |=> slot_narrow_r == $past(narrow_slot); endproperty
   property p_narrow; narrow_slot && bus_req_r && !bus_local_r |-> (bus_addr_r & NARROW_LIMIT_MASK) == 32'h0;
   endproperty
   property p_irq_code; irq_r |-> fault_code_r != FAULT_NONE; endproperty
   property p_irq_hold; irq_r && !fault_clear |=> irq_r; endproperty
   property p_halt; irq_r |-> !bus_req_r && !done_r; endproperty
   a_dir_read: assert property (p_dir_read) else $error("directory read address wrong");
   a_dir_block: assert property (p_dir_block) else $error("directory read above limit not refused");
   a_local: assert property (p_local) else $error("local target decode wrong");
   a_user_lock: assert property (p_user_lock) else $error("directory base changed in user mode");
   a_pdbr_set: assert property (p_pdbr_set) else $error("directory base write lost");
   a_slot: assert property (p_slot) else $error("slot width report wrong");
   a_narrow: assert property (p_narrow) else $error("system access above 16MB in narrow slot");
   a_irq_code: assert property (p_irq_code) else $error("interrupt without fault code");
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped before clear");
   a_halt: assert property (p_halt) else $error("activity while faulted");
endmodule
bind xlate_path xlate_path_checker chk (.*);

// ===== tb/bus_mem_model.sv
// System bus memory holding directory, tables and data
`timescale 1ns/1ps
module bus_mem_model (
   input  wire logic        clock,
   input  wire logic        bus_req_r,
   input  wire logic [31:0] bus_addr_r,
   input  wire logic [3:0]  lag,
   output logic             bus_ack,
   output logic [31:0]      bus_rdata
);
   logic [31:0] mem [logic [31:0]];
   int          cnt = 0;
   initial bus_ack = 1'b0;
   initial bus_rdata = 32'h0;
   // Ack a held request after lag cycles; scramble data otherwise
   always @(posedge clock) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req_r && !bus_ack) begin
         if (cnt >= lag) begin
            bus_ack <= 1'b1;
            bus_rdata <= mem.exists(bus_addr_r) ? mem[bus_addr_r] : 32'h0;
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

// ===== tb/tb_busmaster_address_translation.sv
// Self-checking bench for the translation path
`timescale 1ns/1ps
module tb_busmaster_address_translation;
   import xlate_pkg::*;
   logic        clock, rst_n, narrow_slot, paged_translation_mode, user_mode, pdbr_wr, req_valid, req_write;
   logic        req_ready, done_r, bus_req_r, bus_write_r, bus_local_r, bus_ack, fault_clear, irq_r, slot_narrow_r, lo, wr;
   logic [31:0] pdbr_wdata, vmem_base, vmem_size, req_addr, bus_addr_r, bus_rdata, fault_addr_r, pdbr_r, pa;
   logic [1:0]  fault_code_r;
   logic [3:0]  lag;
   int          fails = 0;
   int          tests_run = 0;
   xlate_path dut (.*);
   bus_mem_model mem_i (.*);
   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Wait for completion or fault, keeping the last acked access
   task automatic wt;
      int n;
      for (n = 0; n < 100; n++) begin
         @(negedge clock);
         if (bus_req_r === 1'b1 && bus_ack === 1'b1) begin
            pa = bus_addr_r;
            lo = bus_local_r;
            wr = bus_write_r;
         end
         if (done_r === 1'b1 || irq_r === 1'b1) break;
      end
      if (n == 100) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic run(input logic [31:0] a);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req_addr = a;
      for (n = 0; n < 20; n++) begin
         if (req_ready === 1'b1) break;
         @(negedge clock);
      end
      if (n == 20) begin
         fails++;
         print_verdict();
      end
      @(negedge clock);
      req_valid = 1'b0;
      wt();
   endtask
   task automatic clear_fault;
      @(negedge clock);
      fault_clear = 1'b1;
      @(negedge clock);
      fault_clear = 1'b0;
      wt();
   endtask
   task automatic t_slot;
      chk("slot", slot_narrow_r, 0);
      narrow_slot = 1'b1;
      repeat (2) @(negedge clock);
      chk("slot", slot_narrow_r, 1);
      narrow_slot = 1'b0;
   endtask
   task automatic t_pdbr;
      pdbr_wr = 1'b1;
      pdbr_wdata = 32'h00001FFF;
      @(negedge clock);
      user_mode = 1'b1;
      pdbr_wdata = 32'h00099000;
      @(negedge clock);
      pdbr_wr = 1'b0;
      user_mode = 1'b0;
      chk("pdbr", pdbr_r, 32'h00001000);
   endtask
   task automatic t_direct;
      run(32'h00800010);
      chk("addr", pa, 32'h00800010);
   endtask
   task automatic t_walk;
      paged_translation_mode = 1'b1;
      req_write = 1'b1;
      mem_i.mem[32'h00001004] = 32'h00002001;
      mem_i.mem[32'h00002008] = 32'h00805001;
      run(32'h00402ABC);
      req_write = 1'b0;
      chk("addr", pa, 32'h00805ABC);
      chk("local", lo, 1);
      chk("wr", wr, 1);
      run(32'h00403123);
      chk("code", {irq_r, fault_code_r}, {1'b1, FAULT_TBL});
      mem_i.mem[32'h0000200C] = 32'h00806001;
      clear_fault();
      chk("addr", pa, 32'h00806123);
   endtask
   task automatic t_fault;
      lag = 4'h3;
      run(32'h00800ABC);
      chk("code", fault_code_r, FAULT_DIR);
      chk("faddr", fault_addr_r, 32'h00800ABC);
      repeat (4) @(negedge clock);
      chk("halt", {irq_r, bus_req_r}, 2'h2);
      mem_i.mem[32'h00001008] = 32'h00003001;
      mem_i.mem[32'h00003000] = 32'h01234001;
      clear_fault();
      chk("addr", pa, 32'h01234ABC);
      chk("local", lo, 0);
      chk("wr", wr, 0);
   endtask
   task automatic t_narrow;
      narrow_slot = 1'b1;
      run(32'h00800ABC);
      chk("code", {irq_r, fault_code_r}, {1'b1, FAULT_RANGE});
      narrow_slot = 1'b0;
      clear_fault();
      chk("addr", pa, 32'h01234ABC);
      paged_translation_mode = 1'b0;
      narrow_slot = 1'b1;
      run(32'h02000000);
      chk("code", {irq_r, fault_code_r}, {1'b1, FAULT_RANGE});
      narrow_slot = 1'b0;
      clear_fault();
      chk("addr", pa, 32'h02000000);
      chk("local", lo, 0);
   endtask
   // Directory above the limit in a narrow slot, then reset while faulted
   task automatic t_reset;
      paged_translation_mode = 1'b1;
      narrow_slot = 1'b1;
      pdbr_wr = 1'b1;
      pdbr_wdata = 32'h02000000;
      @(negedge clock);
      pdbr_wr = 1'b0;
      run(32'h00402ABC);
      chk("code", {irq_r, fault_code_r}, {1'b1, FAULT_RANGE});
      chk("req", bus_req_r, 0);
      rst_n = 1'b0;
      #1;
      chk("rst_pdbr", pdbr_r, PDBR_RESET);
      chk("rst_flags", {req_ready, bus_req_r, done_r, irq_r, fault_code_r}, 6'h00);
      @(negedge clock);
      rst_n = 1'b1;
      narrow_slot = 1'b0;
      paged_translation_mode = 1'b0;
      @(negedge clock);
      run(32'h00800010);
      chk("addr", pa, 32'h00800010);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      {rst_n, narrow_slot, paged_translation_mode, user_mode, pdbr_wr, req_valid, req_write, fault_clear} = '0;
      {pdbr_wdata, req_addr} = '0;
      vmem_base = 32'h00800000;
      vmem_size = 32'h00100000;
      lag = 4'h0;
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      t_slot();
      t_pdbr();
      t_direct();
      t_walk();
      t_fault();
      t_narrow();
      t_reset();
      print_verdict();
   end
endmodule
